// >>> verilog/ext_event_ctrl_params.svh
`ifndef EXT_EVENT_CTRL_PARAMS_SVH
`define EXT_EVENT_CTRL_PARAMS_SVH

`define LINE_COUNT        42
`define CFG_LINE_COUNT    29
`define DIRECT_LINE_COUNT 13
`define MASK_RESET        42'h000_0000_0000
`define CFG_RESET         29'h000_0000
`define SYNC_STAGES       3

`endif

// >>> verilog/ext_event_ctrl_pkg.sv
package ext_event_ctrl_pkg;

  typedef enum logic [1:0] {
    pulse_idle = 2'b00,
    pulse_high = 2'b01,
    pulse_wait = 2'b10
  } pulse_state_t;

endpackage : ext_event_ctrl_pkg

// >>> verilog/event_pulse_gen.sv
`timescale 1ns/1ps
`include "ext_event_ctrl_params.svh"

module event_pulse_gen
  import ext_event_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // combined request and pulse
  input  wire logic req,
  output logic      pulse
);

  pulse_state_t state;
  pulse_state_t next_state;

  always_comb
  begin
    case (state)
      pulse_idle: next_state = req ? pulse_high : pulse_idle;
      pulse_high: next_state = req ? pulse_wait : pulse_idle;
      pulse_wait: next_state = req ? pulse_wait : pulse_idle;
      default:    next_state = pulse_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= pulse_idle;
      pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // one cycle per rising edge of the request, straight from a flop
      pulse <= (next_state == pulse_high);
    end
  end

endmodule : event_pulse_gen

// >>> verilog/ext_event_ctrl.sv
// How it works
// - 42 lines: 29 configurable, 13 direct
// - configurable lines: separate rising and falling detect
// - software trigger acts as edge, self clears
// - interrupt request is event AND irq mask
// - pending flag set with each interrupt request
// - both line kinds can raise cpu events
// - direct lines detect rising edges only
// - enabled event requests ORed before pulse generator
// - event mask separate from interrupt mask
// - processor events never set pending flag
// - wakeup requests driven to power controller
// - wakeup on detected edge or wake pending
// - direct lines hold no wake pending flag
// - wakeup enabled by irq mask OR event mask
// - no interrupt requests for direct lines
// - direct lines: irq mask gates wakeup only
// - processor event output is a pulse
`timescale 1ns/1ps
`include "ext_event_ctrl_params.svh"

module ext_event_ctrl
  import ext_event_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // peripheral event lines, configurable lines in the low bits
  input  wire logic [`LINE_COUNT-1:0]        line_in,
  // configuration
  input  wire logic [`CFG_LINE_COUNT-1:0]    rising_edge_select,
  input  wire logic [`CFG_LINE_COUNT-1:0]    falling_edge_select,
  input  wire logic [`LINE_COUNT-1:0]        irq_mask_bits,
  input  wire logic [`LINE_COUNT-1:0]        event_mask_bits,
  // software trigger writes, one-cycle strobes
  input  wire logic [`CFG_LINE_COUNT-1:0]    soft_trigger_set,
  // write-one-to-clear strobes
  input  wire logic [`CFG_LINE_COUNT-1:0]    irq_pending_clear,
  input  wire logic [`CFG_LINE_COUNT-1:0]    wake_pending_clear,
  // status
  output logic      [`CFG_LINE_COUNT-1:0]    soft_event_trigger,
  output logic      [`CFG_LINE_COUNT-1:0]    irq_pending_flags,
  output logic      [`CFG_LINE_COUNT-1:0]    wake_pending_flags,
  // to interrupt controller, processor and power controller
  output logic      [`CFG_LINE_COUNT-1:0]    irq_req,
  output logic                               cpu_event_input,
  output logic      [`LINE_COUNT-1:0]        wakeup_req
);

  // synchroniser stages and the settled level of every line
  logic [`LINE_COUNT-1:0] sync1;
  logic [`LINE_COUNT-1:0] sync2;
  logic [`LINE_COUNT-1:0] sync3;
  logic [`LINE_COUNT-1:0] level;
  logic [`LINE_COUNT-1:0] agree;
  logic [`LINE_COUNT-1:0] next_level;
  logic [`LINE_COUNT-1:0] rise;
  logic [`LINE_COUNT-1:0] fall;

  // bits that are high now and were low before
  function automatic logic [`LINE_COUNT-1:0] went_high
  (
    input logic [`LINE_COUNT-1:0] now_bits,
    input logic [`LINE_COUNT-1:0] old_bits
  );
    return now_bits & ~old_bits;
  endfunction : went_high

  // configurable lines sit in the low bits
  function automatic logic [`CFG_LINE_COUNT-1:0] cfg_part
  (
    input logic [`LINE_COUNT-1:0] bits
  );
    return bits[`CFG_LINE_COUNT-1:0];
  endfunction : cfg_part

  // direct lines sit above them
  function automatic logic [`DIRECT_LINE_COUNT-1:0] dir_part
  (
    input logic [`LINE_COUNT-1:0] bits
  );
    return bits[`LINE_COUNT-1:`CFG_LINE_COUNT];
  endfunction : dir_part

  // per-line gating of edges by a mask
  function automatic logic [`LINE_COUNT-1:0] masked
  (
    input logic [`LINE_COUNT-1:0] hit_bits,
    input logic [`LINE_COUNT-1:0] mask_bits
  );
    return hit_bits & mask_bits;
  endfunction : masked

  // sticky flag update, set wins over clear
  function automatic logic [`CFG_LINE_COUNT-1:0] sticky_next
  (
    input logic [`CFG_LINE_COUNT-1:0] set_bits,
    input logic [`CFG_LINE_COUNT-1:0] flag_bits,
    input logic [`CFG_LINE_COUNT-1:0] clear_bits
  );
    logic [`CFG_LINE_COUNT-1:0] kept;
    kept = flag_bits & ~clear_bits;
    return set_bits | kept;
  endfunction : sticky_next

  // first stage may go metastable, only later stages are read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= `MASK_RESET;
    end
    else
    begin
      sync1 <= line_in;
    end
  end

  // second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync2 <= `MASK_RESET;
    end
    else
    begin
      sync2 <= sync1;
    end
  end

  // third stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync3 <= `MASK_RESET;
    end
    else
    begin
      sync3 <= sync2;
    end
  end

  // settled level, moves only when stages 2 and 3 agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      level <= `MASK_RESET;
    end
    else
    begin
      level <= next_level;
    end
  end

  // a change counts once stages 2 and 3 agree
  // a line still settling keeps its old level, so no false edge
  assign agree      = ~(sync2 ^ sync3);
  assign next_level = (agree & sync3) | (~agree & level);
  assign rise       = went_high(next_level, level);
  assign fall       = went_high(level, next_level);

  // per-kind views of edges and masks
  logic [`CFG_LINE_COUNT-1:0]    cfg_rise;
  logic [`CFG_LINE_COUNT-1:0]    cfg_fall;
  logic [`CFG_LINE_COUNT-1:0]    cfg_irq_mask;
  logic [`DIRECT_LINE_COUNT-1:0] dir_rise;

  assign cfg_rise     = cfg_part(rise);
  assign cfg_fall     = cfg_part(fall);
  assign cfg_irq_mask = cfg_part(irq_mask_bits);
  assign dir_rise     = dir_part(rise);

  // edge sources of a configurable line
  logic [`CFG_LINE_COUNT-1:0] cfg_rise_hit;
  logic [`CFG_LINE_COUNT-1:0] cfg_fall_hit;
  logic [`CFG_LINE_COUNT-1:0] soft_hit;

  assign cfg_rise_hit = cfg_rise & rising_edge_select;
  assign cfg_fall_hit = cfg_fall & falling_edge_select;
  assign soft_hit     = soft_event_trigger;

  // active edge per line
  logic [`CFG_LINE_COUNT-1:0]    cfg_edge;
  logic [`DIRECT_LINE_COUNT-1:0] dir_edge;
  logic [`LINE_COUNT-1:0]        active_edge;

  assign cfg_edge    = cfg_rise_hit
                     | cfg_fall_hit
                     | soft_hit;
  assign dir_edge    = dir_rise;
  assign active_edge = {dir_edge, cfg_edge};

  // interrupt path, configurable lines only
  logic [`CFG_LINE_COUNT-1:0] next_irq;

  assign next_irq = cfg_edge & cfg_irq_mask;

  // event path: per-line event mask, then one OR
  // direct lines share the same OR, their irq mask plays no part here
  logic [`LINE_COUNT-1:0]        event_lines;
  logic [`CFG_LINE_COUNT-1:0]    cfg_event_lines;
  logic [`DIRECT_LINE_COUNT-1:0] dir_event_lines;
  logic                          cfg_event_any;
  logic                          dir_event_any;
  logic                          event_any;

  assign event_lines     = masked(active_edge, event_mask_bits);
  assign cfg_event_lines = cfg_part(event_lines);
  assign dir_event_lines = dir_part(event_lines);
  assign cfg_event_any   = |cfg_event_lines;
  assign dir_event_any   = |dir_event_lines;
  assign event_any       = cfg_event_any | dir_event_any;

  // wakeup path
  // direct lines keep no flag here, their wakeup lasts one cycle
  logic [`LINE_COUNT-1:0]        wake_enable;
  logic [`LINE_COUNT-1:0]        wake_edge;
  logic [`CFG_LINE_COUNT-1:0]    cfg_wake_edge;
  logic [`DIRECT_LINE_COUNT-1:0] dir_wake_edge;
  logic [`CFG_LINE_COUNT-1:0]    cfg_wake_next;
  logic [`LINE_COUNT-1:0]        next_wakeup;

  assign wake_enable   = irq_mask_bits | event_mask_bits;
  assign wake_edge     = masked(active_edge, wake_enable);
  assign cfg_wake_edge = cfg_part(wake_edge);
  assign dir_wake_edge = dir_part(wake_edge);
  assign cfg_wake_next = cfg_wake_edge | wake_pending_flags;
  assign next_wakeup   = {dir_wake_edge, cfg_wake_next};

  // flag updates, set wins over clear
  // an edge in the cycle of a clear is never lost
  logic [`CFG_LINE_COUNT-1:0] next_pending;
  logic [`CFG_LINE_COUNT-1:0] next_wake_pending;
  logic [`CFG_LINE_COUNT-1:0] next_soft;

  assign next_pending      = sticky_next(next_irq, irq_pending_flags, irq_pending_clear);
  assign next_wake_pending = sticky_next(cfg_wake_edge, wake_pending_flags, wake_pending_clear);
  assign next_soft         = soft_trigger_set;

  // software trigger bits, visible one cycle then cleared
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      soft_event_trigger <= `CFG_RESET;
    end
    else
    begin
      soft_event_trigger <= next_soft;
    end
  end

  // interrupt pending flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_pending_flags <= `CFG_RESET;
    end
    else
    begin
      irq_pending_flags <= next_pending;
    end
  end

  // wakeup pending flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_pending_flags <= `CFG_RESET;
    end
    else
    begin
      wake_pending_flags <= next_wake_pending;
    end
  end

  // interrupt requests
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_req <= `CFG_RESET;
    end
    else
    begin
      irq_req <= next_irq;
    end
  end

  // wakeup requests
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wakeup_req <= `MASK_RESET;
    end
    else
    begin
      wakeup_req <= next_wakeup;
    end
  end

  // registered combined request feeds the pulse generator
  // a request that stays high gives only one pulse
  logic event_req;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      event_req <= 1'b0;
    end
    else
    begin
      event_req <= event_any;
    end
  end

  // one pulse per rise of the combined request
  event_pulse_gen u_pulse
  (
    .clk   (clk),
    .rst   (rst),
    .req   (event_req),
    .pulse (cpu_event_input)
  );

endmodule : ext_event_ctrl

// >>> testbench/ext_event_ctrl_chk.sv
`timescale 1ns/1ps
module ext_event_ctrl_chk (
  // clock, reset and masks
  input wire logic        clk, rst,
  input wire logic [41:0] irq_mask_bits, event_mask_bits,
  // outputs watched
  input wire logic        cpu_event_input,
  input wire logic [41:0] wakeup_req,
  input wire logic [28:0] irq_req, irq_pending_flags, wake_pending_flags, soft_event_trigger
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pulse;
    cpu_event_input ##1 !cpu_event_input;
  endsequence
  a_event_pulse_once: assert property (cpu_event_input |-> s_pulse)
    else $error("event pulse too long");
  a_irq_masked: assert property ((irq_req & ~$past(irq_mask_bits[28:0])) == 0)
    else $error("irq without mask");
  a_irq_sets_pend: assert property ((irq_req & ~irq_pending_flags) == 0)
    else $error("irq without pending");
  a_pend_from_irq: assert property ((irq_pending_flags & ~$past(irq_pending_flags) & ~irq_req) == 0)
    else $error("pending without irq");
  a_trig_self_clear: assert property (|soft_event_trigger |=> (soft_event_trigger & $past(soft_event_trigger)) == 0)
    else $error("trigger stuck");
  a_wake_holds: assert property ((wake_pending_flags & ~wakeup_req[28:0]) == 0)
    else $error("wake pending without wakeup");
  a_direct_wake_mask: assert property ((wakeup_req[41:29] & ~$past(irq_mask_bits[41:29] | event_mask_bits[41:29])) == 0)
    else $error("direct wakeup unmasked");
  a_reset_clear: assert property ($fell(rst) |-> !cpu_event_input && irq_pending_flags == 0 && wakeup_req == 0)
    else $error("state after reset");
endmodule : ext_event_ctrl_chk
bind ext_event_ctrl ext_event_ctrl_chk ext_event_ctrl_chk_i (.*);

// >>> testbench/event_sources.sv
`timescale 1ns/1ps
module event_sources (
  // clock and flip requests
  input  wire logic        clk,
  input  wire logic [41:0] toggle,
  // peripheral lines
  output logic      [41:0] line_in
);
  initial line_in = '0;
  // a requested line flips at the falling edge and holds its level
  always @(negedge clk) line_in <= line_in ^ toggle;
endmodule : event_sources

// >>> testbench/test_ext_event_ctrl.sv
`timescale 1ns/1ps
module test_ext_event_ctrl;
  logic clk = 0, rst = 1, cpu_event_input;
  logic [41:0] toggle = '0, line_in, irq_mask_bits, event_mask_bits, wakeup_req;
  logic [28:0] rising_edge_select, falling_edge_select, soft_trigger_set = '0, irq_pending_clear = '0;
  logic [28:0] wake_pending_clear = '0, soft_event_trigger, irq_pending_flags, wake_pending_flags, irq_req;
  logic [28:0] e_pend = '0, e_wp = '0;
  logic [31:0] r;
  int n_fail = 0, comparisons = 0, seed = 32'hd603ff77, n_ev = 0, n_irq = 0, e_ev = 0, e_irq = 0, i, op;
  int n_wk = 0, e_wk = 0;
  always #20 clk = ~clk;
  event_sources event_sources_i (.*);
  ext_event_ctrl ext_event_ctrl_i (.*);
  always @(posedge clk)
  begin
    n_ev <= n_ev + cpu_event_input;
    n_irq <= n_irq + $countones(irq_req);
    n_wk <= n_wk + $countones(wakeup_req[41:29]);
  end
  task automatic hit(input int k);
    e_irq += int'(k < 29 && irq_mask_bits[k]);
    if (k < 29) e_pend[k] |= irq_mask_bits[k];
    if (k < 29) e_wp[k] |= irq_mask_bits[k] | event_mask_bits[k];
    e_ev += int'(event_mask_bits[k]);
    if (k >= 29) e_wk += int'(irq_mask_bits[k] | event_mask_bits[k]);
  endtask : hit
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    #200000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    irq_mask_bits = 42'({$random(seed), $random(seed)});
    event_mask_bits = 42'({$random(seed), $random(seed)});
    rising_edge_select = 29'($random(seed));
    falling_edge_select = 29'($random(seed));
    repeat (3) @(negedge clk);
    rst <= 0;
    repeat (2) @(negedge clk);
    for (int n = 0; n < 300; n++)
    begin
      i = {$random(seed)} % 42;
      op = {$random(seed)} % 3;
      r = $random(seed);
      if (op == 2)
      begin
        irq_pending_clear <= r[28:0];
        wake_pending_clear <= r[31:3];
        e_pend &= ~r[28:0];
        e_wp &= ~r[31:3];
      end
      else if (op == 1 && i < 29)
      begin
        soft_trigger_set[i] <= 1;
        hit(i);
      end
      else
      begin
        if (i < 29 ? (line_in[i] ? falling_edge_select[i] : rising_edge_select[i]) : !line_in[i]) hit(i);
        toggle[i] <= 1;
      end
      @(negedge clk);
      chk(soft_event_trigger, soft_trigger_set);
      {toggle, soft_trigger_set, irq_pending_clear, wake_pending_clear} <= '0;
      repeat (8) @(negedge clk);
      chk(irq_pending_flags, e_pend);
      chk(wake_pending_flags, e_wp);
      chk(wakeup_req[28:0], e_wp);
      chk(n_irq, e_irq);
      chk(n_ev, e_ev);
      chk(n_wk, e_wk);
    end
    finish_test;
  end
endmodule : test_ext_event_ctrl
